// [hw/dpgp_top.sv]
`timescale 1ns/1ps
`default_nettype none

module dpgp_top #(
    parameter int FW_ADDR_W = dpgp_pkg::FW_ADDR_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wall_supply_detect_input,
    input wire logic cc1_attach_pin,
    input wire logic cc2_attach_pin,
    input wire logic partner_attached,
    input wire logic partner_is_source,
    input wire logic alt_mode_active,
    input wire logic alt_mode_four_lane,
    input wire logic [2:0] mux_en_pin_sel,
    input wire logic [2:0] mux_flip_pin_sel,
    input wire logic [2:0] mux_mode_pin_sel,
    input wire logic cfg_sink_path_en,
    input wire logic contract_valid,
    input wire logic contract_is_source,
    input wire logic [1:0] contract_pdo,
    input wire logic pr_swap_done,
    output logic pe_req_valid,
    output logic [1:0] pe_req_cmd,
    input wire logic pe_req_ack,
    output logic source_role,
    output logic sink_request_enable,
    output logic [2:0] src_pdo_count,
    output logic flash_supply_enable,
    output logic external_power_path,
    output logic plug_event_output,
    output logic select_9v_output,
    output logic select_15v_output,
    output logic select_20v_output,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe,
    output logic i2c_irq_n,
    input wire logic i2c_irq_clear,
    input wire logic fw_start,
    input wire logic fw_valid,
    input wire logic [7:0] fw_data,
    output logic fw_ready,
    output logic flash_wr_valid,
    output logic [FW_ADDR_W-1:0] flash_wr_addr,
    output logic [7:0] flash_wr_data,
    input wire logic flash_wr_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; first stage feeds only the second
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic wall_prev_q;
    logic wall_present;
    logic wall_rise;
    logic wall_fall;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_meta_q <= 3'h0;
            pin_sync_q <= 3'h0;
        end else begin
            pin_meta_q <= {cc2_attach_pin, cc1_attach_pin, wall_supply_detect_input};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Wall edges taken from the settled copy only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wall_prev_q <= 1'b0;
        end else begin
            wall_prev_q <= pin_sync_q[0];
        end
    end

    assign wall_present = pin_sync_q[0];
    assign wall_rise = wall_present & ~wall_prev_q;
    assign wall_fall = ~wall_present & wall_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Power-role policy
    dpgp_pkg::dpgp_state_t state_q;
    dpgp_pkg::dpgp_state_t state_d;
    logic [1:0] cmd_d;

    always_comb begin
        state_d = state_q;
        cmd_d = dpgp_pkg::DPGP_CMD_NONE;
        case (state_q)
            dpgp_pkg::DPGP_ST_DETACHED: begin
                if (partner_attached) begin
                    if (wall_present) begin
                        state_d = dpgp_pkg::DPGP_ST_SRC_ATTACH;
                    end else if (partner_is_source) begin
                        state_d = dpgp_pkg::DPGP_ST_SNK_BOOT;
                    end
                end
            end
            dpgp_pkg::DPGP_ST_SRC_ATTACH: begin
                if (wall_fall) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_RENEG;
                end else if (contract_valid && contract_is_source) begin
                    state_d = dpgp_pkg::DPGP_ST_SRC_CONTRACT;
                end
            end
            dpgp_pkg::DPGP_ST_SRC_CONTRACT: begin
                if (wall_fall) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_RENEG;
                end else if (!contract_valid) begin
                    state_d = dpgp_pkg::DPGP_ST_SRC_ATTACH;
                end
            end
            dpgp_pkg::DPGP_ST_SNK_BOOT: begin
                if (wall_present) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_CAPS;
                end else if (contract_valid && !contract_is_source) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_CONTRACT;
                end
            end
            dpgp_pkg::DPGP_ST_SNK_CONTRACT: begin
                if (wall_present) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_CAPS;
                end else if (!contract_valid) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_BOOT;
                end
            end
            dpgp_pkg::DPGP_ST_SNK_CAPS: begin
                cmd_d = dpgp_pkg::DPGP_CMD_SRC_CAPS;
                if (!wall_present) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_BOOT;
                end else if (pe_req_ack) begin
                    state_d = dpgp_pkg::DPGP_ST_PR_SWAP;
                end
            end
            dpgp_pkg::DPGP_ST_PR_SWAP: begin
                cmd_d = dpgp_pkg::DPGP_CMD_PR_SWAP;
                if (pr_swap_done) begin
                    state_d = dpgp_pkg::DPGP_ST_SRC_ATTACH;
                end else if (!wall_present) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_BOOT;
                end
            end
            dpgp_pkg::DPGP_ST_SNK_RENEG: begin
                cmd_d = dpgp_pkg::DPGP_CMD_SINK_RENEG;
                if (wall_present) begin
                    state_d = dpgp_pkg::DPGP_ST_SRC_ATTACH;
                end else if (pe_req_ack) begin
                    state_d = dpgp_pkg::DPGP_ST_SNK_BOOT;
                end
            end
            default: begin
                state_d = dpgp_pkg::DPGP_ST_DETACHED;
            end
        endcase
        // Detach overrides every state
        if (!partner_attached) begin
            state_d = dpgp_pkg::DPGP_ST_DETACHED;
            cmd_d = dpgp_pkg::DPGP_CMD_NONE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= dpgp_pkg::DPGP_ST_DETACHED;
        end else begin
            state_q <= state_d;
        end
    end

    // Request held through its own accept; dropped when a detach, wall change
    // or finished swap moves the state. Ack is read directly to avoid a loop
    always_comb begin
        pe_req_cmd = cmd_d;
        pe_req_valid = (cmd_d != dpgp_pkg::DPGP_CMD_NONE) &&
                       ((state_q == state_d) || pe_req_ack);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Role and supply outputs, registered
    logic is_source_d;

    assign is_source_d = (state_d == dpgp_pkg::DPGP_ST_SRC_ATTACH) ||
                         (state_d == dpgp_pkg::DPGP_ST_SRC_CONTRACT);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            source_role <= 1'b0;
            sink_request_enable <= 1'b0;
            src_pdo_count <= dpgp_pkg::SRC_PDO_CNT_BUS;
            flash_supply_enable <= 1'b0;
            external_power_path <= 1'b0;
            plug_event_output <= 1'b0;
        end else begin
            source_role <= is_source_d;
            // Never ask for power while the wall supply is there
            sink_request_enable <= partner_attached & ~wall_present & ~is_source_d;
            src_pdo_count <= wall_present ? dpgp_pkg::SRC_PDO_CNT_WALL
                                          : dpgp_pkg::SRC_PDO_CNT_BUS;
            // Flash must be powered from bus even with no wall supply
            flash_supply_enable <= wall_present | partner_attached;
            external_power_path <= cfg_sink_path_en & partner_attached &
                                   ~wall_present & ~is_source_d;
            // Regulator on at 5 V for an attached plug while in a source state
            plug_event_output <= partner_attached & is_source_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Voltage selects: one-hot from the negotiated object, all low for 5 V
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            select_9v_output <= 1'b0;
            select_15v_output <= 1'b0;
            select_20v_output <= 1'b0;
        end else if (state_d == dpgp_pkg::DPGP_ST_SRC_CONTRACT && contract_valid) begin
            select_9v_output <= (contract_pdo == dpgp_pkg::PDO_9V);
            select_15v_output <= (contract_pdo == dpgp_pkg::PDO_15V);
            select_20v_output <= (contract_pdo == dpgp_pkg::PDO_20V);
        end else begin
            // Detach, wall loss or no valid contract: back to default voltage
            select_9v_output <= 1'b0;
            select_15v_output <= 1'b0;
            select_20v_output <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Orientation captured at attach so mid-session CC noise cannot flip lanes
    logic flip_q;
    logic attached_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flip_q <= 1'b0;
            attached_q <= 1'b0;
        end else begin
            attached_q <= partner_attached;
            if (partner_attached && !attached_q) begin
                flip_q <= pin_sync_q[2] & ~pin_sync_q[1];
            end
        end
    end

    dpgp_mux_if mux_bus ();

    assign mux_bus.mux_enable = attached_q & alt_mode_active;
    assign mux_bus.mux_flip = flip_q;
    assign mux_bus.mux_four_lane = alt_mode_four_lane;
    assign mux_bus.en_pin_sel = mux_en_pin_sel;
    assign mux_bus.flip_pin_sel = mux_flip_pin_sel;
    assign mux_bus.mode_pin_sel = mux_mode_pin_sel;

    dpgp_lane_mux u_lane_mux (
        .clk(clk),
        .sys_rst(sys_rst),
        .mif(mux_bus.mux)
    );

    assign gpio_out = mux_bus.gpio_out;
    assign gpio_oe = mux_bus.gpio_oe;

    ////////////////////////////////////////////////////////////////////////////
    // System-change interrupt; a new change beats a same-cycle clear
    logic irq_q;
    logic sys_change;
    logic [1:0] pdo_prev_q;
    logic cv_prev_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pdo_prev_q <= dpgp_pkg::PDO_5V;
            cv_prev_q <= 1'b0;
        end else begin
            pdo_prev_q <= contract_pdo;
            cv_prev_q <= contract_valid;
        end
    end

    assign sys_change = (state_d != state_q) | wall_rise | wall_fall |
                        (contract_valid != cv_prev_q) |
                        (contract_valid & (contract_pdo != pdo_prev_q));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else if (sys_change) begin
            irq_q <= 1'b1;
        end else if (i2c_irq_clear) begin
            irq_q <= 1'b0;
        end
    end

    assign i2c_irq_n = ~irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Firmware bytes from I2C to flash, one-byte stage with rising address
    logic [FW_ADDR_W-1:0] fw_addr_q;

    assign fw_ready = ~flash_wr_valid | flash_wr_ready;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flash_wr_valid <= 1'b0;
            flash_wr_data <= 8'h00;
            flash_wr_addr <= FW_ADDR_W'(dpgp_pkg::FW_ADDR_RST);
            fw_addr_q <= FW_ADDR_W'(dpgp_pkg::FW_ADDR_RST);
        end else if (fw_start) begin
            // Restart drops any byte not yet taken
            flash_wr_valid <= 1'b0;
            fw_addr_q <= FW_ADDR_W'(dpgp_pkg::FW_ADDR_RST);
        end else if (fw_ready) begin
            flash_wr_valid <= fw_valid;
            if (fw_valid) begin
                flash_wr_data <= fw_data;
                flash_wr_addr <= fw_addr_q;
                fw_addr_q <= fw_addr_q + FW_ADDR_W'(1);
            end
        end
    end

endmodule

`default_nettype wire

// [shared/dpgp_pkg.sv]
package dpgp_pkg;

    // General-purpose pin bank
    localparam int NUM_GPIO = 8;
    localparam int GPIO_IDX_W = 3;
    // Pin that carries the wall-supply detect; it is never driven
    localparam logic [2:0] WALL_GPIO_IDX = 3'h2;

    // Reset mapping of the lane-mux events onto the pin bank
    localparam logic [2:0] MUX_EN_PIN_RST = 3'h3;
    localparam logic [2:0] MUX_FLIP_PIN_RST = 3'h4;
    localparam logic [2:0] MUX_MODE_PIN_RST = 3'h5;

    // Negotiated power object index, zero based (PDO1 = 0)
    localparam logic [1:0] PDO_5V = 2'h0;
    localparam logic [1:0] PDO_9V = 2'h1;
    localparam logic [1:0] PDO_15V = 2'h2;
    localparam logic [1:0] PDO_20V = 2'h3;

    // Source power objects offered with and without wall supply
    localparam logic [2:0] SRC_PDO_CNT_WALL = 3'h4;
    localparam logic [2:0] SRC_PDO_CNT_BUS = 3'h1;

    // Firmware image write path
    localparam int FW_DATA_W = 8;
    localparam int FW_ADDR_W = 18;
    localparam logic [17:0] FW_ADDR_RST = 18'h00000;

    // Policy states
    typedef enum logic [2:0] {
        DPGP_ST_DETACHED,
        DPGP_ST_SRC_ATTACH,
        DPGP_ST_SRC_CONTRACT,
        DPGP_ST_SNK_BOOT,
        DPGP_ST_SNK_CONTRACT,
        DPGP_ST_SNK_CAPS,
        DPGP_ST_PR_SWAP,
        DPGP_ST_SNK_RENEG
    } dpgp_state_t;

    // Requests handed to the protocol layer
    typedef enum logic [1:0] {
        DPGP_CMD_SRC_CAPS,
        DPGP_CMD_PR_SWAP,
        DPGP_CMD_SINK_RENEG,
        DPGP_CMD_NONE
    } dpgp_cmd_t;

endpackage

// [shared/dpgp_mux_if.sv]
`timescale 1ns/1ps
`default_nettype none

// Lane-mux control events and their pin mapping
interface dpgp_mux_if;
    logic mux_enable;
    logic mux_flip;
    logic mux_four_lane;
    logic [2:0] en_pin_sel;
    logic [2:0] flip_pin_sel;
    logic [2:0] mode_pin_sel;
    logic [7:0] gpio_out;
    logic [7:0] gpio_oe;

    modport ctrl (
        output mux_enable,
        output mux_flip,
        output mux_four_lane,
        output en_pin_sel,
        output flip_pin_sel,
        output mode_pin_sel,
        input gpio_out,
        input gpio_oe
    );

    modport mux (
        input mux_enable,
        input mux_flip,
        input mux_four_lane,
        input en_pin_sel,
        input flip_pin_sel,
        input mode_pin_sel,
        output gpio_out,
        output gpio_oe
    );
endinterface

`default_nettype wire

// [hw/dpgp_lane_mux.sv]
`timescale 1ns/1ps
`default_nettype none

module dpgp_lane_mux (
    input wire logic clk,
    input wire logic sys_rst,
    dpgp_mux_if.mux mif
);

    ////////////////////////////////////////////////////////////////////////////
    // Place each event on whichever pin it is mapped to
    function automatic logic [7:0] pin_onehot(input logic [2:0] sel);
        logic [7:0] v;
        v = 8'h00;
        v[sel] = 1'b1;
        return v;
    endfunction

    logic [7:0] en_hot;
    logic [7:0] flip_hot;
    logic [7:0] mode_hot;
    logic [7:0] out_d;
    logic [7:0] oe_d;
    logic [7:0] out_q;
    logic [7:0] oe_q;
    logic [7:0] wall_mask;

    // Wall detect pin stays input only, even if mapped by mistake
    assign wall_mask = ~pin_onehot(dpgp_pkg::WALL_GPIO_IDX);
    assign en_hot = pin_onehot(mif.en_pin_sel);
    assign flip_hot = pin_onehot(mif.flip_pin_sel);
    assign mode_hot = pin_onehot(mif.mode_pin_sel);

    // Later mapping wins when two events share a pin
    always_comb begin
        out_d = 8'h00;
        if (mif.mux_enable) begin
            out_d = out_d | en_hot;
        end
        out_d = (out_d & ~flip_hot) | (mif.mux_flip ? flip_hot : 8'h00);
        out_d = (out_d & ~mode_hot) | (mif.mux_four_lane ? mode_hot : 8'h00);
        out_d = out_d & wall_mask;
        oe_d = (en_hot | flip_hot | mode_hot) & wall_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin drive, released during reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            out_q <= 8'h00;
            oe_q <= 8'h00;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    assign mif.gpio_out = out_q;
    assign mif.gpio_oe = oe_q;

endmodule

`default_nettype wire

// [tb/dpgp_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none

// Port-level watch on the power-role policy block
module dpgp_top_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wall_supply_detect_input,
    input wire logic partner_attached,
    input wire logic contract_valid,
    input wire logic contract_is_source,
    input wire logic [1:0] contract_pdo,
    input wire logic pe_req_valid,
    input wire logic source_role,
    input wire logic sink_request_enable,
    input wire logic plug_event_output,
    input wire logic select_9v_output,
    input wire logic select_15v_output,
    input wire logic select_20v_output,
    input wire logic [7:0] gpio_oe,
    input wire logic i2c_irq_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    ////////////////////////////////////////////////////////////////
    // Pin bank and regulator selects
    chk_wall_pin_input: assert property (gpio_oe[2] == 1'b0)
        else $error("wall detect pin is being driven");
    chk_select_one_hot: assert property (
        $onehot0({select_20v_output, select_15v_output, select_9v_output}))
        else $error("more than one voltage select high");
    chk_select_detach_low: assert property (
        (!partner_attached) [*3] |->
        {select_20v_output, select_15v_output, select_9v_output} == 3'h0)
        else $error("voltage select high while detached");
    chk_select_top_pdo: assert property (
        (source_role && partner_attached && contract_valid && contract_is_source
        && contract_pdo == 2'h3) [*2] |-> select_20v_output)
        else $error("top voltage select missing for fourth object");
    chk_plug_with_role: assert property ($rose(source_role) |-> plug_event_output)
        else $error("source role taken without plug event output");

    ////////////////////////////////////////////////////////////////
    // Role policy and system notification
    chk_request_on_detach: assert property (!partner_attached |-> !pe_req_valid)
        else $error("request kept up after detach");
    chk_no_sink_wall: assert property (
        wall_supply_detect_input [*8] |-> !sink_request_enable)
        else $error("sink request while wall supply present");
    chk_irq_wall_edge: assert property (
        $changed(wall_supply_detect_input) && !$past(sys_rst) |-> ##[1:6] !i2c_irq_n)
        else $error("no interrupt after wall supply change");

    // Main scenarios reached
    cover property ($rose(source_role));
    cover property (select_20v_output);
    cover property ($fell(i2c_irq_n));
endmodule

`default_nettype wire

// [tb/dpgp_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// Protocol layer and flash on the far side; acks only after a fixed wait
module dpgp_partner #(
    parameter int ACK_LAT = 6
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pe_req_valid,
    input wire logic [1:0] pe_req_cmd,
    output logic pe_req_ack,
    output logic pr_swap_done,
    input wire logic stall,
    output logic flash_wr_ready
);
    int wait_n;
    int swap_n;
    int beat_n;
    logic [1:0] last_cmd;

    // All changes land just after the edge, never on it
    initial begin
        {pe_req_ack, pr_swap_done, flash_wr_ready} = 3'h0;
        {wait_n, swap_n, beat_n} = '0;
        last_cmd = 2'h3;
        forever begin
            @(posedge clk);
            #1;
            beat_n++;
            // Slow flash takes one write in three
            flash_wr_ready = !stall || (beat_n % 3 == 0);
            pr_swap_done = (swap_n == 1);
            if (swap_n > 0) begin
                swap_n--;
            end
            if (sys_rst) begin
                {pe_req_ack, wait_n, swap_n} = '0;
            end else if (pe_req_ack) begin
                pe_req_ack = 1'b0;
                wait_n = 0;
                // Role swap finishes a few cycles after its acceptance
                if (last_cmd == 2'h1) begin
                    swap_n = 3;
                end
            end else if (pe_req_valid) begin
                wait_n++;
                if (wait_n >= ACK_LAT) begin
                    pe_req_ack = 1'b1;
                    last_cmd = pe_req_cmd;
                end
            end else begin
                wait_n = 0;
            end
        end
    end
endmodule

`default_nettype wire

// [tb/tb_dock_power_role_gpio_policy.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_dock_power_role_gpio_policy;
    localparam int FW_ADDR_W = dpgp_pkg::FW_ADDR_W;
    logic clk, sys_rst, wall_supply_detect_input, cc1_attach_pin, cc2_attach_pin;
    logic partner_attached, partner_is_source, alt_mode_active, alt_mode_four_lane;
    logic [2:0] mux_en_pin_sel, mux_flip_pin_sel, mux_mode_pin_sel, src_pdo_count;
    logic cfg_sink_path_en, contract_valid, contract_is_source, pr_swap_done, stall;
    logic [1:0] contract_pdo, pe_req_cmd;
    logic pe_req_valid, pe_req_ack, source_role, sink_request_enable, flash_supply_enable;
    logic external_power_path, plug_event_output, select_9v_output, select_15v_output;
    logic select_20v_output, i2c_irq_n, i2c_irq_clear, fw_start, fw_valid, fw_ready;
    logic flash_wr_valid, flash_wr_ready;
    logic [7:0] gpio_out, gpio_oe, fw_data, flash_wr_data;
    logic [FW_ADDR_W-1:0] flash_wr_addr;
    logic [FW_ADDR_W-1:0] seen_addr[$];
    logic [7:0] seen_data[$];
    int fails, compares;

    dpgp_top #(.FW_ADDR_W(FW_ADDR_W)) dut (.*);
    dpgp_partner #(.ACK_LAT(6)) u_partner (.*);

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic [2:0] sels();
        return {select_20v_output, select_15v_output, select_9v_output};
    endfunction

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Record every write the flash accepts
    always @(posedge clk) begin
        if (!sys_rst && flash_wr_valid && flash_wr_ready) begin
            seen_addr.push_back(flash_wr_addr);
            seen_data.push_back(flash_wr_data);
        end
    end

    ////////////////////////////////////////////////////////////////
    task automatic t_wall_first();
        wall_supply_detect_input = 1'b1;
        step(4);
        partner_attached = 1'b1;
        repeat (30) if (source_role !== 1'b1) step(1);
        check("source role", source_role, 1);
        check("plug event", plug_event_output, 1);
        check("sink request", sink_request_enable, 0);
        check("pdo count", src_pdo_count, dpgp_pkg::SRC_PDO_CNT_WALL);
        {contract_valid, contract_is_source} = 2'h3;
        for (int i = 0; i < 4; i++) begin
            contract_pdo = i[1:0];
            step(3);
            check("selects", sels(), (i == 0) ? 0 : 1 << (i - 1));
        end
        // Losing the wall supply mid contract
        wall_supply_detect_input = 1'b0;
        repeat (30) if (pe_req_valid !== 1'b1) step(1);
        check("renegotiate", pe_req_cmd, dpgp_pkg::DPGP_CMD_SINK_RENEG);
        {contract_is_source, contract_pdo} = 3'h0;
        repeat (30) if (source_role !== 1'b0) step(1);
        step(2);
        check("role after removal", source_role, 0);
        check("selects", sels(), 0);
        {partner_attached, contract_valid} = 2'h0;
        step(3);
        check("plug after detach", plug_event_output, 0);
    endtask

    task automatic t_sink_boot();
        {partner_is_source, cfg_sink_path_en, partner_attached} = 3'h7;
        repeat (30) if (flash_supply_enable !== 1'b1) step(1);
        step(1);
        check("flash supply", flash_supply_enable, 1);
        check("sink path", external_power_path, 1);
        check("boot role", source_role, 0);
        contract_valid = 1'b1;
        step(3);
        wall_supply_detect_input = 1'b1;
        repeat (30) if (pe_req_valid !== 1'b1) step(1);
        check("caps request", pe_req_cmd, dpgp_pkg::DPGP_CMD_SRC_CAPS);
        repeat (30) if (pe_req_cmd !== dpgp_pkg::DPGP_CMD_PR_SWAP) step(1);
        check("swap request", pe_req_valid, 1);
        check("pdo count", src_pdo_count, dpgp_pkg::SRC_PDO_CNT_WALL);
        repeat (30) if (source_role !== 1'b1) step(1);
        check("swapped role", source_role, 1);
        check("sink request", sink_request_enable, 0);
        {partner_attached, contract_valid, wall_supply_detect_input} = 3'h0;
        step(6);
    endtask

    task automatic t_lane_mux();
        {mux_en_pin_sel, mux_flip_pin_sel, mux_mode_pin_sel} = {3'h0, 3'h7, 3'h5};
        alt_mode_active = 1'b1;
        for (int k = 0; k < 2; k++) begin
            {cc1_attach_pin, cc2_attach_pin, alt_mode_four_lane} = (k == 0) ? 3'h3 : 3'h4;
            step(4);
            partner_attached = 1'b1;
            step(5);
            check("mux pins", gpio_out, (k == 0) ? 8'ha1 : 8'h01);
            check("mux drive", gpio_oe, 8'ha1);
            partner_attached = 1'b0;
            step(6);
        end
    endtask

    task automatic t_irq();
        i2c_irq_clear = 1'b1;
        step(1);
        i2c_irq_clear = 1'b0;
        step(1);
        check("irq idle", i2c_irq_n, 1);
        wall_supply_detect_input = 1'b1;
        step(6);
        check("irq on wall", i2c_irq_n, 0);
        i2c_irq_clear = 1'b1;
        step(1);
        i2c_irq_clear = 1'b0;
        step(1);
        check("irq cleared", i2c_irq_n, 1);
    endtask

    task automatic t_fw();
        stall = 1'b1;
        fw_start = 1'b1;
        step(1);
        fw_start = 1'b0;
        for (int b = 0; b < 3; b++) begin
            fw_valid = 1'b1;
            fw_data = 8'h5a + b[7:0];
            // Judge acceptance at the edge itself, as the design sees it
            do @(posedge clk); while (fw_ready !== 1'b1);
            #1;
        end
        fw_valid = 1'b0;
        step(12);
        check("write count", seen_addr.size(), 3);
        foreach (seen_addr[j]) begin
            check("flash address", seen_addr[j], j);
            check("flash data", seen_data[j], 8'h5a + j);
        end
    endtask

    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {fails, compares} = '0;
        sys_rst = 1'b1;
        {wall_supply_detect_input, cc1_attach_pin, cc2_attach_pin, partner_attached} = '0;
        {partner_is_source, alt_mode_active, alt_mode_four_lane, cfg_sink_path_en} = '0;
        {mux_en_pin_sel, mux_flip_pin_sel, mux_mode_pin_sel, contract_pdo} = '0;
        {contract_valid, contract_is_source, i2c_irq_clear, fw_start, fw_valid} = '0;
        {fw_data, stall} = '0;
        repeat (2) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        step(1);
        check("reset selects", sels(), 0);
        check("reset irq", i2c_irq_n, 1);
        check("reset pdo count", src_pdo_count, dpgp_pkg::SRC_PDO_CNT_BUS);
        t_wall_first();
        t_sink_boot();
        t_lane_mux();
        t_irq();
        t_fw();
        end_of_test();
    end

    // Hang guard, well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule

bind dpgp_top dpgp_top_monitor u_mon (.*);

`default_nettype wire
